// file: shared/rfse_params.svh
// constants of the ramped FSK sweep engine and its host controller
// What this block does
// - ramped FSK steps through intermediate tones
// - host programs step word as positive
// - low tone first, high second not enforced; host flags FTW1 MSB above FTW2 MSB in pin status bit 4
// - host pulses sweep clear low-high-low first
// - 20-bit rate down-counter pulses at zero
// - FSK pin level change starts rate counter
// - pulse interval is (count+1) times two clocks
// - host rate count from 1 to 2^20-1
// - counter stops at destination; tone holds
// - tick adds step going up, subtracts it going down; offset feeds phase accumulator
// - early pin toggle reverses ramp at once
// - triangle bit sweeps both ways, ignores pin
// - triangle sweep starts at tone pin selects, heads to the other
// - step and rate accepted mid-ramp
// - sweep clear one-clock pulse restarts from start
// - sweep clear held repulses every update edge
// - sweep clear restarts even when settled
// - all clear holds both accumulators at zero
// - ramped FSK stays between the two tones
// - three mode bits, 010 ramped, 011 chirp
// - buffers reach core only on update edge
`ifndef RFSE_PARAMS_SVH
`define RFSE_PARAMS_SVH
`define RFSE_A_FTW1 6'h04
`define RFSE_A_FTW2 6'h0A
`define RFSE_A_DFW 6'h10
`define RFSE_A_UPD 6'h16
`define RFSE_A_RATE 6'h1A
`define RFSE_A_CTRL 6'h1F
`define RFSE_MODE_LSB 0
`define RFSE_MODE_RAMP 3'h2
`define RFSE_MODE_CHIRP 3'h3
`define RFSE_B_TRI 3
`define RFSE_B_CLR1 4
`define RFSE_B_CLR2 5
`define RFSE_B_INTUPD 6
`define RFSE_CTRL_RST 8'h40
`define RFSE_UPD_RST 32'h0000_00FF
`define RFSE_H_CMD 8'h00
`define RFSE_H_PINS 8'h04
`define RFSE_CLK_NS 100
`endif

// file: shared/rfse_pkg.sv
// types shared by the sweep engine and its host controller
package rfse_pkg;
   typedef enum logic [1:0] {RFSE_H_IDLE = 2'b01, RFSE_H_SEQ = 2'b10} rfse_hstate_e;
   typedef struct packed {
      logic [47:0] buf_ftw1;
      logic [47:0] buf_ftw2;
      logic [47:0] buf_dfw;
      logic [31:0] buf_upd;
      logic [19:0] buf_rate;
      logic [7:0] buf_ctrl;
      logic [47:0] act_ftw1;
      logic [47:0] act_ftw2;
      logic [47:0] act_dfw;
      logic [31:0] act_upd;
      logic [19:0] act_rate;
      logic [7:0] act_ctrl;
      logic fsk_m;
      logic fsk_s;
      logic fsk_q;
      logic upd_m;
      logic upd_s;
      logic upd_q;
      logic [31:0] upd_cnt;
      logic half;
      logic [19:0] rate_cnt;
      logic running;
      logic tri_dir;
      logic tri_q;
      logic [47:0] pos;
      logic [47:0] phase;
      logic [47:0] freq;
      logic tick;
   } rfse_dev_s;
   typedef struct packed {
      rfse_hstate_e state;
      logic [3:0] step;
      logic fsk;
      logic upd;
      logic wr_en;
      logic [5:0] wr_addr;
      logic [7:0] wr_data;
      logic [7:0] ctrl_sh;
      logic [11:0] rate_hi;
      logic [7:0] f1_msb;
      logic [7:0] f2_msb;
      logic [31:0] prdata;
      logic err;
   } rfse_host_s;
endpackage : rfse_pkg

// file: shared/rfse_link_if.sv
// byte programming port, FSK pin and update pin between host and engine
`timescale 1ns/1ns
`default_nettype none
interface rfse_link_if;
   logic wr_en;
   logic [5:0] wr_addr;
   logic [7:0] wr_data;
   logic fsk;
   logic io_update;
   modport dev (input wr_en, input wr_addr, input wr_data, input fsk, input io_update);
   modport host (output wr_en, output wr_addr, output wr_data, output fsk, output io_update);
endinterface : rfse_link_if
`default_nettype wire

// file: src/rfse_device.sv
// ramped FSK sweep engine: buffer registers, update logic, ramp and phase accumulator
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "rfse_params.svh"
module rfse_device (
   input wire logic i_clk,
   input wire logic i_rst,
   rfse_link_if.dev link,
   output logic [47:0] o_freq_word,
   output logic [47:0] o_phase,
   output logic o_ramp_tick,
   output logic o_running
);
   import rfse_pkg::*;

   localparam rfse_dev_s DEV_RST = '{
      buf_ctrl: `RFSE_CTRL_RST,
      act_ctrl: `RFSE_CTRL_RST,
      buf_upd: `RFSE_UPD_RST,
      act_upd: `RFSE_UPD_RST,
      upd_cnt: `RFSE_UPD_RST,
      default: '0
   };

   rfse_dev_s s_reg;
   rfse_dev_s s_next;

   // bytes arrive most significant first, lowest address holds the top byte
   function automatic logic [47:0] put48(
      input logic [47:0] v,
      input logic [5:0] base,
      input logic [5:0] a,
      input logic [7:0] d
   );
      logic [47:0] r;
      logic [5:0] k;
      r = v;
      k = 6'(base + 6'h05 - a);
      r[{k[2:0], 3'h0} +: 8] = d;
      return r;
   endfunction : put48

   function automatic logic in_rng(
      input logic [5:0] a,
      input logic [5:0] base,
      input logic [5:0] last
   );
      return (a >= base) && (a <= 6'(base + last));
   endfunction : in_rng

   always_comb
   begin
      logic upd_evt;
      logic clr1_evt;
      logic clr2;
      logic ramp;
      logic tri_on;
      logic dir;
      logic [47:0] span;
      logic [47:0] target;
      logic [48:0] sum;
      logic [5:0] a;
      logic [5:0] k;
      upd_evt = 1'b0;
      clr1_evt = 1'b0;
      clr2 = 1'b0;
      ramp = 1'b0;
      tri_on = 1'b0;
      dir = 1'b0;
      span = '0;
      target = '0;
      sum = '0;
      a = link.wr_addr;
      k = '0;
      s_next = s_reg;
      s_next.tick = 1'b0;

      // pins come from the far party, so two stages before use
      s_next.fsk_m = link.fsk;
      s_next.fsk_s = s_reg.fsk_m;
      s_next.fsk_q = s_reg.fsk_s;
      s_next.upd_m = link.io_update;
      s_next.upd_s = s_reg.upd_m;
      s_next.upd_q = s_reg.upd_s;

      // byte writes land in buffer registers only
      if (link.wr_en)
      begin
         if (in_rng(a, `RFSE_A_FTW1, 6'h05))
         begin
            s_next.buf_ftw1 = put48(s_reg.buf_ftw1, `RFSE_A_FTW1, a, link.wr_data);
         end
         if (in_rng(a, `RFSE_A_FTW2, 6'h05))
         begin
            s_next.buf_ftw2 = put48(s_reg.buf_ftw2, `RFSE_A_FTW2, a, link.wr_data);
         end
         if (in_rng(a, `RFSE_A_DFW, 6'h05))
         begin
            s_next.buf_dfw = put48(s_reg.buf_dfw, `RFSE_A_DFW, a, link.wr_data);
         end
         if (in_rng(a, `RFSE_A_UPD, 6'h03))
         begin
            k = 6'(`RFSE_A_UPD + 6'h03 - a);
            s_next.buf_upd[{k[1:0], 3'h0} +: 8] = link.wr_data;
         end
         if (a == `RFSE_A_RATE)
         begin
            s_next.buf_rate[19:16] = link.wr_data[3:0];
         end
         if (a == 6'(`RFSE_A_RATE + 6'h01))
         begin
            s_next.buf_rate[15:8] = link.wr_data;
         end
         if (a == 6'(`RFSE_A_RATE + 6'h02))
         begin
            s_next.buf_rate[7:0] = link.wr_data;
         end
         if (a == `RFSE_A_CTRL)
         begin
            s_next.buf_ctrl = link.wr_data;
         end
      end

      // update source: internal down-counter or synchronised pin edge
      if (s_reg.act_ctrl[`RFSE_B_INTUPD])
      begin
         upd_evt = (s_reg.upd_cnt == 32'h0000_0000);
         s_next.upd_cnt = upd_evt ? s_reg.buf_upd : s_reg.upd_cnt - 32'h0000_0001;
      end
      else
      begin
         upd_evt = s_reg.upd_s & ~s_reg.upd_q;
         s_next.upd_cnt = s_reg.buf_upd;
      end
      if (upd_evt)
      begin
         s_next.act_ftw1 = s_reg.buf_ftw1;
         s_next.act_ftw2 = s_reg.buf_ftw2;
         s_next.act_dfw = s_reg.buf_dfw;
         s_next.act_rate = s_reg.buf_rate;
         s_next.act_upd = s_reg.buf_upd;
         s_next.act_ctrl = s_reg.buf_ctrl;
         // a held clear bit fires again on every update edge
         clr1_evt = s_reg.buf_ctrl[`RFSE_B_CLR1];
      end

      clr2 = s_reg.act_ctrl[`RFSE_B_CLR2];
      ramp = (s_reg.act_ctrl[`RFSE_MODE_LSB +: 3] == `RFSE_MODE_RAMP);
      tri_on = ramp & s_reg.act_ctrl[`RFSE_B_TRI];
      s_next.tri_q = tri_on;
      span = s_reg.act_ftw2 - s_reg.act_ftw1;
      dir = tri_on ? s_reg.tri_dir : s_reg.fsk_s;
      target = dir ? span : 48'h0000_0000_0000;

      if (!ramp || clr2)
      begin
         // chirp and the other modes are not swept by this engine
         s_next.pos = '0;
         s_next.running = 1'b0;
         s_next.half = 1'b0;
      end
      else
      begin
         if (tri_on && !s_reg.tri_q)
         begin
            s_next.pos = s_reg.fsk_s ? span : 48'h0000_0000_0000;
            s_next.tri_dir = ~s_reg.fsk_s;
            s_next.running = 1'b1;
            s_next.half = 1'b0;
            s_next.rate_cnt = s_reg.act_rate;
         end
         else if (clr1_evt)
         begin
            // back to where this ramp started, keep direction and rate
            s_next.pos = dir ? 48'h0000_0000_0000 : span;
            s_next.running = 1'b1;
            s_next.half = 1'b0;
            s_next.rate_cnt = s_reg.act_rate;
         end
         else if (!tri_on && (s_reg.fsk_s != s_reg.fsk_q))
         begin
            // a toggle mid-ramp just turns the target round
            s_next.running = 1'b1;
            s_next.half = 1'b0;
            s_next.rate_cnt = s_reg.act_rate;
         end
         else if (s_reg.running)
         begin
            s_next.half = ~s_reg.half;
            if (s_reg.half)
            begin
               if (s_reg.rate_cnt == 20'h0_0000)
               begin
                  s_next.tick = 1'b1;
                  s_next.rate_cnt = s_reg.act_rate;
               end
               else
               begin
                  s_next.rate_cnt = s_reg.rate_cnt - 20'h0_0001;
               end
            end
            if (s_reg.half && (s_reg.rate_cnt == 20'h0_0000))
            begin
               if (dir)
               begin
                  sum = {1'b0, s_reg.pos} + {1'b0, s_reg.act_dfw};
                  s_next.pos = (sum >= {1'b0, span}) ? span : sum[47:0];
               end
               else
               begin
                  s_next.pos = (s_reg.pos <= s_reg.act_dfw) ? 48'h0000_0000_0000 :
                     s_reg.pos - s_reg.act_dfw;
               end
               if (s_next.pos == target)
               begin
                  if (tri_on)
                  begin
                     s_next.tri_dir = ~s_reg.tri_dir;
                  end
                  else
                  begin
                     s_next.running = 1'b0;
                  end
               end
            end
         end
      end

      if (clr2)
      begin
         s_next.freq = '0;
         s_next.phase = '0;
      end
      else
      begin
         s_next.freq = ramp ? s_reg.act_ftw1 + s_next.pos : s_reg.act_ftw1;
         s_next.phase = s_reg.phase + s_reg.freq;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s_reg <= DEV_RST;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign o_freq_word = s_reg.freq;
   assign o_phase = s_reg.phase;
   assign o_ramp_tick = s_reg.tick;
   assign o_running = s_reg.running;
endmodule : rfse_device
`default_nettype wire

// file: src/rfse_host.sv
// host controller: APB command registers driving the engine's byte port and pins
`timescale 1ns/1ns
`default_nettype none
`include "rfse_params.svh"
module rfse_host (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   rfse_link_if.host link
);
   import rfse_pkg::*;

   localparam rfse_host_s HOST_RST = '{
      state: RFSE_H_IDLE,
      ctrl_sh: `RFSE_CTRL_RST,
      default: '0
   };

   rfse_host_s h_reg;
   rfse_host_s h_next;

   always_comb
   begin
      logic [5:0] a;
      logic [7:0] d;
      logic take;
      a = i_pwdata[13:8];
      d = i_pwdata[7:0];
      take = i_psel & i_penable & i_pwrite & (h_reg.state == RFSE_H_IDLE);
      h_next = h_reg;
      h_next.wr_en = 1'b0;
      h_next.upd = 1'b0;
      // read data and error are set up during the setup cycle
      if (i_psel && !i_penable)
      begin
         h_next.err = (i_paddr != `RFSE_H_CMD) && (i_paddr != `RFSE_H_PINS);
         h_next.prdata = '0;
         if (i_paddr == `RFSE_H_CMD)
         begin
            h_next.prdata = {18'h0_0000, h_reg.wr_addr, h_reg.wr_data};
         end
         if (i_paddr == `RFSE_H_PINS)
         begin
            h_next.prdata = {27'h000_0000, (h_reg.f1_msb > h_reg.f2_msb) ,
               (h_reg.state != RFSE_H_IDLE), 2'h0, h_reg.fsk};
         end
      end
      case (h_reg.state)
         RFSE_H_IDLE:
         begin
            if (take && (i_paddr == `RFSE_H_CMD))
            begin
               if ((a == `RFSE_A_DFW) && (h_reg.ctrl_sh[2:0] == `RFSE_MODE_RAMP))
               begin
                  d[7] = 1'b0;
               end
               if ((a == 6'(`RFSE_A_RATE + 6'h02)) && (h_reg.rate_hi == 12'h000) &&
                  (d == 8'h00))
               begin
                  d = 8'h01;
               end
               h_next.wr_en = 1'b1;
               h_next.wr_addr = a;
               h_next.wr_data = d;
               if (a == `RFSE_A_CTRL)
               begin
                  h_next.ctrl_sh = d;
               end
               if (a == `RFSE_A_RATE)
               begin
                  h_next.rate_hi[11:8] = d[3:0];
               end
               if (a == 6'(`RFSE_A_RATE + 6'h01))
               begin
                  h_next.rate_hi[7:0] = d;
               end
               if (a == `RFSE_A_FTW1)
               begin
                  h_next.f1_msb = d;
               end
               if (a == `RFSE_A_FTW2)
               begin
                  h_next.f2_msb = d;
               end
            end
            if (take && (i_paddr == `RFSE_H_PINS))
            begin
               h_next.fsk = i_pwdata[0];
               h_next.upd = i_pwdata[1];
               if (i_pwdata[2])
               begin
                  h_next.state = RFSE_H_SEQ;
                  h_next.step = 4'h0;
               end
            end
         end
         RFSE_H_SEQ:
         begin
            // write, update, then two idle cycles: the engine's pin sync takes three
            // clocks to apply an update, so the next byte must not overtake it
            if (h_reg.step[1:0] == 2'h0)
            begin
               h_next.wr_en = 1'b1;
               h_next.wr_addr = `RFSE_A_CTRL;
               h_next.wr_data = h_reg.ctrl_sh;
               h_next.wr_data[`RFSE_B_CLR1] = (h_reg.step == 4'h4);
               h_next.ctrl_sh[`RFSE_B_CLR1] = 1'b0;
            end
            else if (h_reg.step[1:0] == 2'h1)
            begin
               h_next.upd = 1'b1;
            end
            h_next.step = h_reg.step + 4'h1;
            if (h_reg.step == 4'h9)
            begin
               h_next.state = RFSE_H_IDLE;
            end
         end
         default:
         begin
            h_next.state = RFSE_H_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         h_reg <= HOST_RST;
      end
      else
      begin
         h_reg <= h_next;
      end
   end

   // stalling the bus keeps commands from colliding with the clear sequence
   assign o_pready = (h_reg.state == RFSE_H_IDLE);
   assign o_prdata = h_reg.prdata;
   assign o_pslverr = h_reg.err & i_psel & i_penable & o_pready;
   assign link.wr_en = h_reg.wr_en;
   assign link.wr_addr = h_reg.wr_addr;
   assign link.wr_data = h_reg.wr_data;
   assign link.fsk = h_reg.fsk;
   assign link.io_update = h_reg.upd;
endmodule : rfse_host
`default_nettype wire

// file: verif/rfse_assertions.sv
// concurrent checks on the link between host controller and sweep engine, and on the engine's tick and running outputs
`timescale 1ns/1ns
`default_nettype none
module rfse_assertions (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic wr_en,
   input wire logic [5:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic fsk,
   input wire logic io_update,
   input wire logic o_ramp_tick,
   input wire logic o_running
);
   logic [2:0] mode_reg;
   logic [3:0] rate_top_reg;
   logic [7:0] rate_mid_reg;
   // shadows of what the host has sent, so byte-level guards know the mode and the upper rate bytes
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         mode_reg <= 3'h0;
      else if (wr_en && wr_addr == 6'h1F)
         mode_reg <= wr_data[2:0];
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         rate_top_reg <= 4'h0;
      else if (wr_en && wr_addr == 6'h1A)
         rate_top_reg <= wr_data[3:0];
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         rate_mid_reg <= 8'h00;
      else if (wr_en && wr_addr == 6'h1B)
         rate_mid_reg <= wr_data;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   sequence s_ctrl_low;
      wr_en && wr_addr == 6'h1F && !wr_data[4];
   endsequence
   sequence s_ctrl_high;
      wr_en && wr_addr == 6'h1F && wr_data[4];
   endsequence
   chk_clear_order: assert property (s_ctrl_low ##1 io_update ##3 s_ctrl_high |=> io_update ##3 s_ctrl_low ##1 io_update) else $error("sweep clear sequence broken");
   chk_step_positive: assert property (wr_en && wr_addr == 6'h10 && mode_reg == 3'h2 |-> !wr_data[7]) else $error("negative step word sent");
   chk_rate_nonzero: assert property (wr_en && wr_addr == 6'h1C && rate_top_reg == 4'h0 && rate_mid_reg == 8'h00 |-> wr_data != 8'h00) else $error("zero rate count sent");
   chk_update_pulse: assert property (io_update |=> !io_update) else $error("update pin held high");
   chk_write_pulse: assert property (wr_en |=> !wr_en) else $error("write strobe held high");
   chk_write_update_apart: assert property (!(wr_en && io_update)) else $error("byte write in update cycle");
   chk_tick_gap: assert property (o_ramp_tick |=> !o_ramp_tick [*3]) else $error("ramp ticks too close");
   chk_tick_running: assert property (o_ramp_tick |-> o_running || $past(o_running)) else $error("tick while stopped");
endmodule : rfse_assertions
`default_nettype wire

// file: verif/ramped_fsk_sweep_engine_test.sv
// self-checking bench: host controller and sweep engine joined by the link
`timescale 1ns/1ns
`default_nettype none
module ramped_fsk_sweep_engine_test;
   logic clk, rst, psel, pen, pwr, pready, pslverr, tick, run, fk, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [47:0] freq, phase, f1, f2, lf;
   logic [47:0] seen[$], exp_q[$];
   int gaps[$];
   int n_fail, n_compared, cyc, lt, s, k, seed;
   rfse_link_if link();
   rfse_host i_rfse_host (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .link(link));
   rfse_device i_rfse_device (.i_clk(clk), .i_rst(rst), .link(link), .o_freq_word(freq),
      .o_phase(phase), .o_ramp_tick(tick), .o_running(run));
   rfse_assertions i_rfse_assertions (.i_clk(clk), .i_rst(rst), .wr_en(link.wr_en),
      .wr_addr(link.wr_addr), .wr_data(link.wr_data), .fsk(link.fsk),
      .io_update(link.io_update), .o_ramp_tick(tick), .o_running(run));
   task automatic end_of_test;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   task automatic cmp(input logic [47:0] g, input logic [47:0] x);
      n_compared++;
      if (g !== x)
      begin
         n_fail++;
         $display("wrong value at %0t got %h expected %h", $time, g, x);
      end
   endtask : cmp
   // records every change of tuning word and the spacing of ramp ticks
   always @(posedge clk)
   begin
      cyc++;
      if (freq !== lf) seen.push_back(freq);
      lf = freq;
      if (tick === 1'b1)
      begin
         if (lt >= 0) gaps.push_back(cyc - lt);
         lt = cyc;
      end
      if (cyc > 60000)
      begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic dev(input logic [5:0] a, input logic [7:0] d);
      apb(1'b1, 8'h00, {18'h0, a, d});
   endtask : dev
   // synchronised pin changes need a few clocks to reach the core
   task automatic pins(input logic [2:0] v);
      apb(1'b1, 8'h04, {29'h0, v});
      repeat (6) @(posedge clk);
   endtask : pins
   task automatic word(input logic [5:0] b, input logic [47:0] v);
      for (int i = 0; i < 6; i++)
         dev(b + 6'(i), v[47 - 8 * i -: 8]);
   endtask : word
   task automatic rate(input logic [19:0] n);
      dev(6'h1A, {4'h0, n[19:16]});
      dev(6'h1B, n[15:8]);
      dev(6'h1C, n[7:0]);
      pins({2'b01, fk});
   endtask : rate
   task automatic settle;
      repeat (8) @(posedge clk);
      while (run !== 1'b0)
         @(posedge clk);
      repeat (4) @(posedge clk);
   endtask : settle
   task automatic go(input logic v);
      seen.delete();
      exp_q.delete();
      gaps.delete();
      lt = -1;
      fk = v;
      pins({2'b00, fk});
   endtask : go
   task automatic exp_up;
      for (k = 1; k * s < 1000; k++)
         exp_q.push_back(f1 + 48'(k * s));
      exp_q.push_back(f2);
   endtask : exp_up
   task automatic exp_dn;
      for (k = 1; k * s < 1000; k++)
         exp_q.push_back(f2 - 48'(k * s));
      exp_q.push_back(f1);
   endtask : exp_dn
   task automatic check(input logic strict);
      if (strict) cmp(48'(seen.size()), 48'(exp_q.size()));
      for (int i = 0; i < exp_q.size() && i < seen.size(); i++)
         cmp(seen[i], exp_q[i]);
   endtask : check
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fk = 1'b0;
      lf = 48'h0;
      cyc = 0;
      lt = -1;
      n_fail = 0;
      n_compared = 0;
      seed = 79623;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      f1 = 48'h0000_0123_4000;
      f2 = f1 + 48'h3E8;
      s = 40 + ($random(seed) & 63);
      // internal update is on after reset: let it carry the mode change
      dev(6'h1F, 8'h02);
      repeat (300) @(posedge clk);
      word(6'h04, f1);
      word(6'h0A, f2);
      word(6'h10, 48'(s));
      rate(20'h2);
      go(1'b1);
      exp_up();
      settle();
      check(1'b1);
      foreach (gaps[i]) cmp(48'(gaps[i]), 48'h6);
      cmp(48'(gaps.size()), 48'(exp_q.size() - 1));
      go(1'b0);
      exp_dn();
      settle();
      check(1'b1);
      rate(20'h14);
      go(1'b1);
      while (seen.size() < 2)
         @(posedge clk);
      fk = 1'b0;
      pins({2'b00, fk});
      settle();
      exp_q = {f1 + 48'(s), f1 + 48'(2 * s), f1 + 48'(s), f1};
      check(1'b1);
      go(1'b1);
      settle();
      go(1'b1);
      pins(3'b101);
      exp_q.push_back(f1);
      exp_up();
      settle();
      check(1'b1);
      go(1'b1);
      dev(6'h1F, 8'h0A);
      pins(3'b011);
      exp_dn();
      exp_q.push_back(f1 + 48'(s));
      exp_q.push_back(f1 + 48'(2 * s));
      while (seen.size() < 2)
         @(posedge clk);
      fk = 1'b0;
      pins({2'b00, fk});
      while (seen.size() < exp_q.size())
         @(posedge clk);
      check(1'b0);
      dev(6'h1F, 8'h22);
      pins({2'b01, fk});
      repeat (4) @(posedge clk);
      cmp(freq, 48'h0);
      cmp(phase, 48'h0);
      dev(6'h1F, 8'h03);
      pins({2'b01, fk});
      cmp(freq, f1);
      cmp(48'(phase != 48'h0), 48'h1);
      apb(1'b0, 8'h08, 32'h0);
      cmp(48'(e), 48'h1);
      cmp(48'(r), 48'h0);
      apb(1'b0, 8'h04, 32'h0);
      cmp(48'(r[0]), 48'(fk));
      end_of_test();
   end
endmodule : ramped_fsk_sweep_engine_test
`default_nettype wire
